// file: afc_core.sv
// Automatic flow control: configuration register, threshold tracking, pause and jam requests.
//
// Summary of operation
// - No pause request and no backpressure are issued while the MAC transmitter is disabled.
// - The high threshold is bits 23:16 in 64-byte units and flow control triggers when the FIFO reaches it.
// - In full duplex reaching the high threshold sends exactly one pause frame using the MAC pause time value.
// - In half duplex after the high threshold every frame matching the enabled criteria is jammed for the set time.
// - The low threshold is bits 15:8 in 64-byte units and a zero-time pause is sent when the FIFO falls below it.
// - The zero-time pause is sent only after a high-threshold pause was sent and while flow control is enabled.
// - The jam duration code sits in bits 7:4, sets the jam length and is unused in full duplex.
// - Bit 3 jams multicast frames once the threshold is reached, in half duplex only.
// - Bit 2 jams broadcast frames once the threshold is reached, in half duplex only.
// - Bit 1 jams frames addressed to this station once the threshold is reached, in half duplex only.
// - All fields reset to zero and bits 31:24 are read-only.
// - Bit 0 acts on any frame, enables full-duplex pause and overrides bits 3:1.
// - With bit 0 in half duplex the jam starts on the next preamble; in full duplex the pause is requested at once.
// - Duration codes map to 5 to 600 us at 100 Mb/s, each 2.2 us longer at 10 Mb/s.
`timescale 1ns/1ps
module afc_core
  import afc_pkg::*;
#(
  parameter int LW = LVL_W
)
(
  // Clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              rst_b_in,
  input  wire logic              clk_en_in,
  // Register port
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  input  wire logic [31:0]       reg_wdata_in,
  output logic      [31:0]       reg_rdata_out,
  // MAC status
  input  wire logic              tx_enabled_in,
  input  wire logic              full_duplex_in,
  input  wire logic              speed_10m_in,
  input  wire logic [15:0]       pause_time_value_in,
  // Receive FIFO and receiver
  input  wire logic [LW-1:0]     rx_fifo_level_in,
  input  wire afc_rx_evt_t       rx_evt_in,
  // Requests to the MAC transmitter
  output logic                   pause_req_out,
  output logic      [15:0]       pause_time_out,
  input  wire logic              pause_ack_in,
  output logic                   backpressure_out
);

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_HI_REQ = 4'h2,
    ST_PAUSED = 4'h4,
    ST_LO_REQ = 4'h8
  } afc_fd_state_t;

  flow_control_config_t        cfg_ff;
  afc_fd_state_t   fd_state_ff;
  afc_fd_state_t   nxt_fd_state;
  logic [CNT_W-1:0] jam_cnt_ff;
  logic [CNT_W-1:0] jam_cycles;
  logic            at_high;
  logic            below_low;
  logic            fc_enabled;
  logic            frame_match;
  logic            jam_start;

  afc_level_cmp #(
    .LW (LW)
  ) u_cmp (
    .level_in      (rx_fifo_level_in),
    .high_thr_in   (cfg_ff.high_thr),
    .low_thr_in    (cfg_ff.low_thr),
    .at_high_out   (at_high),
    .below_low_out (below_low)
  );

  afc_dur_lut u_dur (
    .code_in      (cfg_ff.jam_dur),
    .speed_10m_in (speed_10m_in),
    .cycles_out   (jam_cycles)
  );

  // Configuration register; the upper byte is never stored.
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
      cfg_ff <= flow_control_config_t'(FLOW_CFG_RESET[HI_MSB:0]);
    else if (clk_en_in && reg_wr_in && reg_addr_in == FLOW_CFG_OFFSET)
      cfg_ff <= flow_control_config_t'(reg_wdata_in[HI_MSB:0]);
  end

  always_comb
  begin
    reg_rdata_out = 32'h0000_0000;
    if (reg_rd_in && reg_addr_in == FLOW_CFG_OFFSET)
      reg_rdata_out = {8'h00, cfg_ff};
  end

  assign fc_enabled = cfg_ff.any_frame | cfg_ff.jam_multi | cfg_ff.jam_bcast | cfg_ff.jam_own;

  // Any-frame mode reacts on the preamble and skips the address decode.
  always_comb
  begin
    if (cfg_ff.any_frame)
      frame_match = rx_evt_in.preamble;
    else
      frame_match = rx_evt_in.addr_valid &&
                    ((cfg_ff.jam_multi && rx_evt_in.is_multi) ||
                     (cfg_ff.jam_bcast && rx_evt_in.is_bcast) ||
                     (cfg_ff.jam_own && rx_evt_in.is_own));
  end

  assign jam_start = !full_duplex_in && tx_enabled_in && at_high && frame_match;

  // Half-duplex jam timer; a new match restarts the full period.
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
      jam_cnt_ff <= '0;
    else if (clk_en_in)
    begin
      if (!tx_enabled_in || full_duplex_in)
        jam_cnt_ff <= '0;
      else if (jam_start)
        jam_cnt_ff <= jam_cycles;
      else if (jam_cnt_ff != '0)
        jam_cnt_ff <= jam_cnt_ff - CNT_W'(1);
    end
  end

  assign backpressure_out = (jam_cnt_ff != '0) && tx_enabled_in && !full_duplex_in;

  // Full-duplex pause sequencing: one pause at the high level, one zero pause below the low level.
  always_comb
  begin
    nxt_fd_state = fd_state_ff;
    case (fd_state_ff)
      ST_IDLE:
        if (full_duplex_in && cfg_ff.any_frame && tx_enabled_in && at_high)
          nxt_fd_state = ST_HI_REQ;
      ST_HI_REQ:
        if (!tx_enabled_in)
          nxt_fd_state = ST_IDLE;
        else if (pause_ack_in)
          nxt_fd_state = ST_PAUSED;
      ST_PAUSED:
        if (!fc_enabled)
          nxt_fd_state = ST_IDLE;
        else if (below_low && tx_enabled_in)
          nxt_fd_state = ST_LO_REQ;
      ST_LO_REQ:
        if (!tx_enabled_in || !fc_enabled)
          nxt_fd_state = ST_IDLE;
        else if (pause_ack_in)
          nxt_fd_state = ST_IDLE;
      default:
        nxt_fd_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
      fd_state_ff <= ST_IDLE;
    else if (clk_en_in)
      fd_state_ff <= nxt_fd_state;
  end

  // The pause time is latched when a request is raised so it stays stable while pending.
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
      pause_time_out <= 16'h0000;
    else if (clk_en_in && fd_state_ff == ST_IDLE && nxt_fd_state == ST_HI_REQ)
      pause_time_out <= pause_time_value_in;
    else if (clk_en_in && fd_state_ff == ST_PAUSED && nxt_fd_state == ST_LO_REQ)
      pause_time_out <= 16'h0000;
  end

  assign pause_req_out = tx_enabled_in && (fd_state_ff == ST_HI_REQ || fd_state_ff == ST_LO_REQ);

  // Assertions.
  no_req_txoff_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !tx_enabled_in |-> !pause_req_out && !backpressure_out)
    else $error("request while transmitter disabled");

  hi_req_time_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (clk_en_in && fd_state_ff == ST_IDLE && nxt_fd_state == ST_HI_REQ)
      |=> pause_time_out == $past(pause_time_value_in) && fd_state_ff == ST_HI_REQ)
    else $error("high pause time wrong");

  jam_load_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (clk_en_in && jam_start) |=> jam_cnt_ff == $past(jam_cycles))
    else $error("jam period not loaded");

  zero_pause_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (fd_state_ff == ST_LO_REQ) |-> pause_time_out == 16'h0000)
    else $error("low pause time not zero");

  lo_after_hi_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (fd_state_ff != ST_LO_REQ) ##1 (fd_state_ff == ST_LO_REQ) |-> $past(fd_state_ff) == ST_PAUSED)
    else $error("zero pause without prior pause");

  fd_no_jam_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    full_duplex_in |-> !backpressure_out)
    else $error("backpressure in full duplex");

  cfg_reset_a : assert property (@(posedge clk_sys_in)
    !rst_b_in |=> cfg_ff == flow_control_config_t'(FLOW_CFG_RESET[HI_MSB:0]))
    else $error("config not cleared by reset");

  upper_ro_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    reg_rdata_out[31:24] == 8'h00)
    else $error("reserved byte not zero");

  jam_count_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (clk_en_in && jam_cnt_ff > CNT_W'(1) && !jam_start && tx_enabled_in && !full_duplex_in)
      |=> jam_cnt_ff == $past(jam_cnt_ff) - CNT_W'(1))
    else $error("jam timer not counting down");

  cfg_write_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (clk_en_in && reg_wr_in && reg_addr_in == FLOW_CFG_OFFSET)
      |=> {8'h00, cfg_ff} == ($past(reg_wdata_in) & FLOW_CFG_WMASK))
    else $error("config write not stored");

  cfg_freeze_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !clk_en_in |=> $stable(cfg_ff))
    else $error("config changed while clock enable low");

  rd_other_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (reg_rd_in && reg_addr_in != FLOW_CFG_OFFSET) |-> reg_rdata_out == 32'h0000_0000)
    else $error("read of other offset not zero");

  rd_cfg_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (reg_rd_in && reg_addr_in == FLOW_CFG_OFFSET) |-> reg_rdata_out[HI_MSB:0] == cfg_ff)
    else $error("config read wrong");

  one_pause_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (fd_state_ff == ST_PAUSED) |=> fd_state_ff != ST_HI_REQ)
    else $error("second pause at high level");

  hi_ack_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (clk_en_in && fd_state_ff == ST_HI_REQ && tx_enabled_in && pause_ack_in) |=> fd_state_ff == ST_PAUSED)
    else $error("accepted pause not retired");

  hi_hold_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (fd_state_ff == ST_HI_REQ) ##1 (fd_state_ff == ST_HI_REQ) |-> $stable(pause_time_out))
    else $error("pause time moved while pending");

  hd_no_pause_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (fd_state_ff == ST_IDLE && !full_duplex_in) |=> fd_state_ff == ST_IDLE)
    else $error("pause raised in half duplex");

  idle_quiet_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (clk_en_in && jam_cnt_ff == '0 && !jam_start) |=> jam_cnt_ff == '0)
    else $error("jam without matching frame");

  lo_wait_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (fd_state_ff == ST_PAUSED && !below_low) |=> fd_state_ff != ST_LO_REQ)
    else $error("zero pause above low level");

  lo_enable_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (clk_en_in && fd_state_ff == ST_PAUSED && !fc_enabled) |=> fd_state_ff == ST_IDLE)
    else $error("zero pause kept while disabled");

  jam_end_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (clk_en_in && jam_cnt_ff == CNT_W'(1) && !jam_start) |=> jam_cnt_ff == '0)
    else $error("jam overran its period");

  multi_jam_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (clk_en_in && !full_duplex_in && tx_enabled_in && at_high && !cfg_ff.any_frame &&
     rx_evt_in.addr_valid && cfg_ff.jam_multi && rx_evt_in.is_multi) |=> jam_cnt_ff == $past(jam_cycles))
    else $error("multicast frame not jammed");

  bcast_jam_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (clk_en_in && !full_duplex_in && tx_enabled_in && at_high && !cfg_ff.any_frame &&
     rx_evt_in.addr_valid && cfg_ff.jam_bcast && rx_evt_in.is_bcast) |=> jam_cnt_ff == $past(jam_cycles))
    else $error("broadcast frame not jammed");

  own_jam_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (clk_en_in && !full_duplex_in && tx_enabled_in && at_high && !cfg_ff.any_frame &&
     rx_evt_in.addr_valid && cfg_ff.jam_own && rx_evt_in.is_own) |=> jam_cnt_ff == $past(jam_cycles))
    else $error("own-address frame not jammed");

  any_jam_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (clk_en_in && !full_duplex_in && tx_enabled_in && at_high && cfg_ff.any_frame && rx_evt_in.preamble)
      |=> jam_cnt_ff == $past(jam_cycles))
    else $error("preamble not jammed in any-frame mode");

  fd_needs_any_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (fd_state_ff == ST_IDLE && !cfg_ff.any_frame) |=> fd_state_ff == ST_IDLE)
    else $error("pause without any-frame bit");

  fd_at_once_a : assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (clk_en_in && fd_state_ff == ST_IDLE && full_duplex_in && cfg_ff.any_frame && tx_enabled_in && at_high)
      |=> fd_state_ff == ST_HI_REQ)
    else $error("pause not requested at once");

endmodule

// file: afc_dur_lut.sv
// Converts a jam duration code and link speed into a cycle count.
`timescale 1ns/1ps
module afc_dur_lut
  import afc_pkg::*;
(
  // Selection
  input  wire logic [3:0]       code_in,
  input  wire logic             speed_10m_in,
  // Result
  output logic      [CNT_W-1:0] cycles_out
);

  localparam int NS_TAB [16] = '{5000, 10000, 15000, 25000, 50000, 100000, 150000, 200000,
                                 250000, 300000, 350000, 400000, 450000, 500000, 550000, 600000};

  int unsigned ns_total;

  always_comb
  begin
    ns_total = NS_TAB[code_in] + (speed_10m_in ? EXTRA_10M_NS : 0);
    // Round up so the jam never runs short of the programmed time.
    cycles_out = CNT_W'((ns_total + CLK_NS - 1) / CLK_NS);
  end

endmodule

// file: afc_level_cmp.sv
// Compares FIFO occupancy in bytes against thresholds counted in 64-byte units.
`timescale 1ns/1ps
module afc_level_cmp
  import afc_pkg::*;
#(
  parameter int LW = LVL_W
)
(
  // Inputs
  input  wire logic [LW-1:0] level_in,
  input  wire logic [7:0]    high_thr_in,
  input  wire logic [7:0]    low_thr_in,
  // Results
  output logic               at_high_out,
  output logic               below_low_out
);

  logic [LW-1:0] high_bytes;
  logic [LW-1:0] low_bytes;

  always_comb
  begin
    high_bytes    = LW'({high_thr_in, 6'h00});
    low_bytes     = LW'({low_thr_in, 6'h00});
    at_high_out   = (level_in >= high_bytes);
    below_low_out = (level_in < low_bytes);
  end

endmodule

// file: afc_mac_model.sv
// Behavioural MAC transmitter that accepts pause requests after a chosen delay.
`timescale 1ns/1ps
module afc_mac_model
(
  // Clock and control
  input  wire logic       clk_sys_in,
  input  wire logic [3:0] lat_in,
  // Pause handshake
  input  wire logic       pause_req_in,
  output logic            pause_ack_out
);
  logic [3:0] wait_ff = 4'h0;
  initial pause_ack_out = 1'b0;
  // The ack moves at the falling edge so the block samples it cleanly.
  always @(negedge clk_sys_in)
  begin
    pause_ack_out <= pause_req_in && !pause_ack_out && wait_ff >= lat_in;
    wait_ff       <= (pause_req_in && !pause_ack_out) ? wait_ff + 4'h1 : 4'h0;
  end
endmodule

// file: afc_pkg.sv
// Package for the automatic flow control block: register layout, timing constants and carriers.
package afc_pkg;

  // Register map.
  localparam logic [7:0]  FLOW_CFG_OFFSET = 8'hAC;
  localparam logic [31:0] FLOW_CFG_RESET  = 32'h0000_0000;
  localparam logic [31:0] FLOW_CFG_WMASK  = 32'h00FF_FFFF;

  // Field positions in flow_control_config.
  localparam int HI_MSB    = 23;
  localparam int HI_LSB    = 16;
  localparam int LO_MSB    = 15;
  localparam int LO_LSB    = 8;
  localparam int DUR_MSB   = 7;
  localparam int DUR_LSB   = 4;
  localparam int BIT_MULTI = 3;
  localparam int BIT_BCAST = 2;
  localparam int BIT_OWN   = 1;
  localparam int BIT_ANY   = 0;

  // One threshold unit is 64 bytes, a shift of six.
  localparam int UNIT_BYTES = 64;
  localparam int UNIT_SHIFT = 6;
  localparam int LVL_W      = 14;

  // Jam durations in nanoseconds at 100 Mb/s and the 10 Mb/s extension.
  localparam int CLK_NS       = 25;
  localparam int EXTRA_10M_NS = 2200;
  localparam int DUR_BASE_NS  = 5000;
  localparam int DUR_STEP_NS  = 50000;
  localparam int CNT_W        = 16;

  // Flow control configuration fields.
  typedef struct packed {
    logic [7:0] high_thr;
    logic [7:0] low_thr;
    logic [3:0] jam_dur;
    logic       jam_multi;
    logic       jam_bcast;
    logic       jam_own;
    logic       any_frame;
  } flow_control_config_t;

  // Receive-side frame event from the MAC receiver.
  typedef struct packed {
    logic preamble;
    logic addr_valid;
    logic is_multi;
    logic is_bcast;
    logic is_own;
  } afc_rx_evt_t;

endpackage

// file: auto_flow_control_tb.sv
// Self-checking testbench for the automatic flow control block.
`timescale 1ns/1ps
module auto_flow_control_tb;
  import afc_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [7:0]  reg_addr_in = 8'h00;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic        tx_enabled_in = 1'b1;
  logic        full_duplex_in = 1'b1;
  logic        speed_10m_in = 1'b0;
  logic [15:0] pause_time_value_in = 16'h0;
  logic [13:0] rx_fifo_level_in = 14'h0;
  afc_rx_evt_t rx_evt_in = '0;
  logic [3:0]  lat = 4'h0;
  logic        clk_en = 1'b1;
  logic [3:0]  code;
  logic [31:0] reg_rdata_out;
  logic [15:0] pause_time_out;
  logic        pause_req_out;
  logic        pause_ack_in;
  logic        backpressure_out;
  logic [35:0] notes[$];
  int          failures = 0;
  int          total_checks = 0;
  int          seed = 32'hB61D;
  int          bp_len = 0;
  int          dur_ns;

  always #12.5 clk_sys_in = ~clk_sys_in;

  afc_core dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .tx_enabled_in(tx_enabled_in), .full_duplex_in(full_duplex_in), .speed_10m_in(speed_10m_in),
    .pause_time_value_in(pause_time_value_in), .rx_fifo_level_in(rx_fifo_level_in), .rx_evt_in(rx_evt_in),
    .pause_req_out(pause_req_out), .pause_time_out(pause_time_out), .pause_ack_in(pause_ack_in),
    .backpressure_out(backpressure_out));

  afc_mac_model mac (.clk_sys_in(clk_sys_in), .lat_in(lat), .pause_req_in(pause_req_out),
    .pause_ack_out(pause_ack_in));

  task automatic end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // A result with no note pending is compared against zero, so it always fails.
  task automatic take(input logic [35:0] seen);
    if (notes.size() == 0)
      check(seen, 36'h0);
    else
      check(seen, notes.pop_front());
  endtask

  always @(posedge clk_sys_in)
  begin
    if (reg_rd_in)
      take({4'h1, reg_rdata_out});
    if (pause_req_out && pause_ack_in)
      take({4'h2, 16'h0, pause_time_out});
    if (backpressure_out)
      bp_len++;
    else if (bp_len != 0)
    begin
      take({4'h3, bp_len[31:0]});
      bp_len = 0;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  task automatic wr(input logic [31:0] d);
    reg_addr_in = FLOW_CFG_OFFSET;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    tick(1);
    reg_wr_in = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    notes.push_back({4'h1, exp});
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    tick(1);
    reg_rd_in = 1'b0;
    tick(1);
  endtask

  task automatic pulse(input logic [4:0] e);
    rx_evt_in = afc_rx_evt_t'(e);
    tick(1);
    rx_evt_in = '0;
    tick(4);
  endtask

  task automatic drain;
    int i;
    for (i = 0; i < 30000 && notes.size() != 0; i++)
      tick(1);
    if (notes.size() != 0)
    begin
      failures++;
      end_of_test();
    end
  endtask

  task automatic expect_jam(input logic [3:0] c, input logic ten);
    dur_ns = (c < 4'h3) ? 5000 * (c + 1) : (c == 4'h3) ? 25000 : 50000 * (c - 3);
    notes.push_back({4'h3, (dur_ns + (ten ? 2200 : 0) + 24) / 25});
  endtask

  initial
  begin
    pause_time_value_in = 16'($random(seed));
    tick(5);
    rst_b_in = 1'b1;
    rd(FLOW_CFG_OFFSET, FLOW_CFG_RESET);
    wr(32'hFFFF_FFFF);
    rd(FLOW_CFG_OFFSET, 32'h00FF_FFFF);
    rd(8'hB0, 32'h0);
    // A write with the clock enable low must leave the register untouched.
    clk_en = 1'b0;
    wr(32'h0012_3456);
    clk_en = 1'b1;
    rd(FLOW_CFG_OFFSET, 32'h00FF_FFFF);
    wr(32'h0004_0201);
    rx_fifo_level_in = 14'd255;
    tick(10);
    notes.push_back({4'h2, 16'h0, pause_time_value_in});
    rx_fifo_level_in = 14'd256;
    tick(40);
    rx_fifo_level_in = 14'd128;
    tick(10);
    notes.push_back({4'h2, 32'h0});
    lat = 4'h3;
    rx_fifo_level_in = 14'd127;
    drain();
    // With the transmitter off, neither a pause nor a jam may appear.
    tx_enabled_in = 1'b0;
    full_duplex_in = 1'b0;
    rx_fifo_level_in = 14'd300;
    pulse(5'h10);
    repeat (20)
    begin
      tick(1);
      check({34'h0, pause_req_out, backpressure_out}, 36'h0);
    end
    tx_enabled_in = 1'b1;
    rx_fifo_level_in = 14'd64;
    wr(32'h0001_0001);
    expect_jam(4'h0, 1'b0);
    pulse(5'h10);
    drain();
    speed_10m_in = 1'b1;
    code = 4'($random(seed));
    for (int k = 1; k < 4; k++)
    begin
      wr({16'h0100, code, 4'h0} | (32'h1 << k));
      pulse(5'h08 | (5'h01 << (k % 3)));
      expect_jam(code, 1'b1);
      pulse(5'h08 | (5'h01 << (k - 1)));
      drain();
    end
    // Class bits are inert in full duplex; any jam here is flagged by the per-cycle check below.
    full_duplex_in = 1'b1;
    wr(32'h0001_00FE);
    pulse(5'h0F);
    repeat (20)
    begin
      tick(1);
      check({34'h0, pause_req_out, backpressure_out}, 36'h0);
    end
    end_of_test();
  end
endmodule
